// ===== core/lbph_bus_ctrl.v
// local bus control: page select, hold handshake, ready wait states
// Behaviour
// - page_select_n is inverted page_status_bit
// - page_select_n valid with address during address_latch
// - force page_select_n high for traps, interrupts, I/O
// - load status updates page_select_n from new bit
// - long prefixes invert page on next operand
// - fetch codes are 0011 and 0010
// - after cycle ends, output hold_ack_code all high
// - ack for a quarter, then release bus lines
// - next state pulses address_latch, then releases it
// - clock_output keeps toggling during hold
// - hold release restores outputs, resumes processing
// - hold sampled every falling clock_output edge
// - hold at reset start blocks memory cycles
// - reset code shown before ack while reset low
// - low ready at hold release extends hold
// - low ready inserts wait states in all cycles
// - first-state ready low adds one wait each
// - ready sampled on every falling clock_output edge
// - internal cycles carry internal codes, start latched
// - interlock code 000, may persist into alu cycle
`timescale 1ns/100ps
module lbph_bus_ctrl (
  input wire clk,
  input wire resetn,
  input wire reset_code_req,
  input wire hold_n,
  input wire ready,
  input wire cyc_req,
  input wire [1:0] cyc_kind,
  input wire [3:0] cyc_code,
  input wire cyc_write,
  input wire [15:0] cyc_addr,
  input wire [15:0] cyc_wdata,
  input wire page_status_bit,
  input wire force_page_high,
  input wire load_status_strobe,
  input wire load_status_value,
  input wire long_source_prefix,
  input wire long_dest_prefix,
  input wire operand_is_source,
  input wire operand_is_dest,
  output reg cyc_done,
  output reg cyc_accept,
  output reg clock_output,
  output reg address_latch,
  output reg address_latch_oe_n,
  output reg storage_cycle_n,
  output reg read_write_n,
  output reg [2:0] bus_status_code,
  output reg read_strobe_n,
  output reg write_strobe_io_clock,
  output reg ctrl_oe_n,
  output reg [15:0] ad_out,
  output reg ad_oe_n,
  output reg page_select_n,
  output reg in_hold
);
`include "lbph_defines.vh"
  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_DATA = 6'h04;
  localparam ST_ACK = 6'h08;
  localparam ST_HOLD = 6'h10;
  localparam ST_RESET = 6'h20;

  wire [1:0] quarter;
  wire fall_enable;
  reg [5:0] state;
  reg [5:0] next_state;
  reg page_bit;
  reg src_invert;
  reg dst_invert;
  reg hold_req;
  reg ready_smp;
  reg hold_at_reset;
  reg [1:0] kind;
  reg io_second;
  reg [3:0] code;
  reg write;
  reg [15:0] addr;
  reg [15:0] wdata;
  reg force_high;
  reg inv_now;

  // memory-class status codes drive storage_cycle_n low
  function is_mem_code;
    input [3:0] c;
    begin
      is_mem_code = ~c[3];
    end
  endfunction

  // page select from status bit with forcing and prefix inversion
  function page_level;
    input bit8;
    input forced;
    input invert;
    begin
      if (forced)
        page_level = 1'b1;
      else
        page_level = ~(bit8 ^ invert);
    end
  endfunction

  lbph_phase u_phase (
    .clk(clk),
    .resetn(resetn),
    .quarter(quarter),
    .fall_enable(fall_enable)
  );

  // clock_output runs in every state, hold included
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      clock_output <= 1'b1;
    else
      clock_output <= ~quarter[1];
  end

  // falling-edge sampling of hold and ready, in every cycle type
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_req <= 1'b0;
      ready_smp <= 1'b1;
    end else if (fall_enable) begin
      hold_req <= ~hold_n;
      ready_smp <= ready;
    end
  end

  // page status tracking; load status takes effect for the next cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_bit <= 1'b0;
      src_invert <= 1'b0;
      dst_invert <= 1'b0;
    end else begin
      if (load_status_strobe)
        page_bit <= load_status_value;
      else
        page_bit <= page_status_bit;
      // prefix arms inversion for one operand access only
      if (long_source_prefix)
        src_invert <= 1'b1;
      else if (cyc_accept && operand_is_source)
        src_invert <= 1'b0;
      if (long_dest_prefix)
        dst_invert <= 1'b1;
      else if (cyc_accept && operand_is_dest)
        dst_invert <= 1'b0;
    end
  end

  // state sequencing at the machine state boundary (quarter 3)
  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (!reset_code_req)
          next_state = (hold_at_reset || hold_req) ? ST_ACK : ST_IDLE;
      end
      ST_IDLE: begin
        if (hold_req)
          next_state = ST_ACK;
        else if (cyc_req)
          next_state = ST_ADDR;
      end
      ST_ADDR: next_state = ST_DATA;
      ST_DATA: begin
        // wait while ready low; io needs two states
        if (ready_smp && !(kind == `LBPH_KIND_IO && !io_second)) begin
          if (hold_req)
            next_state = ST_ACK;
          else
            next_state = ST_IDLE;
        end
      end
      ST_ACK: next_state = ST_HOLD;
      ST_HOLD: begin
        // a hold taken at reset also ends once hold is removed
        if (!hold_req && ready_smp)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // main state register with captured cycle request
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RESET;
      kind <= `LBPH_KIND_INT;
      code <= `LBPH_CODE_RESET;
      write <= 1'b0;
      addr <= 16'h0000;
      wdata <= 16'h0000;
      force_high <= 1'b0;
      inv_now <= 1'b0;
      io_second <= 1'b0;
      hold_at_reset <= 1'b0;
      cyc_accept <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      cyc_accept <= 1'b0;
      cyc_done <= 1'b0;
      if (reset_code_req) begin
        state <= ST_RESET;
        hold_at_reset <= ~hold_n;
      end else if (quarter == `LBPH_QUARTERS) begin
        state <= next_state;
        if (state == ST_HOLD && next_state == ST_IDLE)
          hold_at_reset <= 1'b0;
        if (state == ST_DATA)
          io_second <= 1'b1;
        if (next_state == ST_ADDR) begin
          cyc_accept <= 1'b1;
          kind <= cyc_kind;
          code <= cyc_code;
          write <= cyc_write;
          addr <= cyc_addr;
          wdata <= cyc_wdata;
          force_high <= force_page_high | (cyc_kind == `LBPH_KIND_IO);
          inv_now <= (operand_is_source & src_invert) |
                     (operand_is_dest & dst_invert);
          io_second <= 1'b0;
        end
        if (state == ST_DATA && next_state != ST_DATA)
          cyc_done <= 1'b1;
      end
    end
  end

  // bus pin drive; every output registered
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      address_latch <= 1'b0;
      address_latch_oe_n <= 1'b0;
      storage_cycle_n <= 1'b1;
      read_write_n <= 1'b1;
      bus_status_code <= 3'h2;
      read_strobe_n <= 1'b1;
      write_strobe_io_clock <= 1'b1;
      ctrl_oe_n <= 1'b0;
      ad_out <= 16'h0000;
      ad_oe_n <= 1'b0;
      page_select_n <= 1'b1;
      in_hold <= 1'b0;
    end else begin
      in_hold <= (state == ST_HOLD) || (state == ST_ACK);
      case (state)
        ST_RESET: begin
          {storage_cycle_n, bus_status_code} <= `LBPH_CODE_RESET;
          address_latch <= 1'b0;
          address_latch_oe_n <= 1'b0;
          ctrl_oe_n <= 1'b0;
          ad_oe_n <= 1'b0;
          read_strobe_n <= 1'b1;
          write_strobe_io_clock <= 1'b1;
        end
        ST_ADDR: begin
          // address, page and code valid with latch high
          address_latch <= (quarter < 2'h2);
          address_latch_oe_n <= 1'b0;
          ctrl_oe_n <= 1'b0;
          ad_oe_n <= 1'b0;
          {storage_cycle_n, bus_status_code} <= code;
          // internal cycles show read_write_n low
          read_write_n <= (kind == `LBPH_KIND_INT) ? 1'b0 : ~write;
          ad_out <= addr;
          page_select_n <= is_mem_code(code) ?
            page_level(page_bit, force_high, inv_now) : 1'b1;
          read_strobe_n <= 1'b1;
          write_strobe_io_clock <= 1'b1;
        end
        ST_DATA: begin
          address_latch <= 1'b0;
          // internal cycles other than the alu codes keep strobes idle
          if (kind != `LBPH_KIND_INT ||
              code == `LBPH_CODE_ALU || code == `LBPH_CODE_ALU_LOCKED) begin
            read_strobe_n <= write;
            write_strobe_io_clock <= ~write;
            ad_oe_n <= ~write;
            ad_out <= wdata;
          end
        end
        ST_ACK: begin
          // ack for the first quarter, released at latch fall
          if (quarter == 2'h0) begin
            {storage_cycle_n, bus_status_code} <= `LBPH_CODE_HOLD_ACK;
            read_write_n <= 1'b1;
            page_select_n <= 1'b1; // non-memory code, page idles high
            address_latch <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_io_clock <= 1'b1;
          end else begin
            address_latch <= 1'b0;
            ctrl_oe_n <= 1'b1;
            ad_oe_n <= 1'b1;
          end
        end
        ST_HOLD: begin
          // latch pulse at state start, then released for the hold
          if (address_latch_oe_n == 1'b0 && quarter == 2'h0)
            address_latch <= 1'b1;
          else if (quarter == 2'h1) begin
            address_latch <= 1'b0;
            address_latch_oe_n <= 1'b1;
          end
          ctrl_oe_n <= 1'b1;
          ad_oe_n <= 1'b1;
        end
        default: begin
          // idle: outputs driven again after hold
          address_latch <= 1'b0;
          address_latch_oe_n <= 1'b0;
          ctrl_oe_n <= 1'b0;
          ad_oe_n <= 1'b0;
          read_strobe_n <= 1'b1;
          write_strobe_io_clock <= 1'b1;
        end
      endcase
    end
  end
endmodule // lbph_bus_ctrl

// ===== core/lbph_defines.vh
// constants for the local bus paging, hold and wait block
`ifndef LBPH_DEFINES_VH
`define LBPH_DEFINES_VH
// bus status codes {storage_cycle_n, bst1, bst2, bst3}
`define LBPH_CODE_LOCKED_SRC 4'h0
`define LBPH_CODE_SRC 4'h1
`define LBPH_CODE_IMM_FETCH 4'h2
`define LBPH_CODE_INSTR_FETCH 4'h3
`define LBPH_CODE_DST 4'h4
`define LBPH_CODE_INT_ACK 4'h5
`define LBPH_CODE_WORKSPACE 4'h6
`define LBPH_CODE_GEN_MEM 4'h7
`define LBPH_CODE_ALU_LOCKED 4'h8
`define LBPH_CODE_ALU 4'h9
`define LBPH_CODE_RESET 4'hA
`define LBPH_CODE_IO 4'hB
`define LBPH_CODE_WP 4'hC
`define LBPH_CODE_FLAGS 4'hD
`define LBPH_CODE_MACRO 4'hE
`define LBPH_CODE_HOLD_ACK 4'hF
// clock_output divider: four quarter phases per machine state
`define LBPH_QUARTERS 2'h3
// cycle kinds requested by the core
`define LBPH_KIND_MEM 2'h0
`define LBPH_KIND_IO 2'h1
`define LBPH_KIND_INT 2'h2
`endif

// ===== core/lbph_phase.v
// quarter-phase generator for the machine state clock
`timescale 1ns/100ps
module lbph_phase (
  input wire clk,
  input wire resetn,
  output reg [1:0] quarter,
  output reg fall_enable
);
`include "lbph_defines.vh"
  // quarter counter; fall_enable marks the falling edge of clock_output
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quarter <= 2'h0;
      fall_enable <= 1'b0;
    end else begin
      quarter <= quarter + 2'h1;
      fall_enable <= (quarter == 2'h1);
    end
  end
endmodule // lbph_phase

// ===== sim/lbph_bus_ctrl_assertions.sv
// assertion checker for the local bus control ports
`timescale 1ns/100ps
module lbph_checker (
  input wire clk,
  input wire resetn,
  input wire reset_code_req,
  input wire ready,
  input wire page_status_bit,
  input wire cyc_accept,
  input wire cyc_done,
  input wire clock_output,
  input wire address_latch,
  input wire address_latch_oe_n,
  input wire storage_cycle_n,
  input wire read_write_n,
  input wire [2:0] bus_status_code,
  input wire ctrl_oe_n,
  input wire ad_oe_n,
  input wire page_select_n,
  input wire in_hold
);
  wire [3:0] code = {storage_cycle_n, bus_status_code};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // hold entry: all-high code first, lines float a quarter later
  sequence s_ack; {code, read_write_n} == 5'h1F; endsequence
  sequence s_float; ctrl_oe_n && ad_oe_n; endsequence
  a_clock_period_kept: assert property (
    $rose(clock_output) |-> ##4 $rose(clock_output))
    else $error("clock period");
  a_ack_then_float: assert property (
    $rose(in_hold) |-> s_ack ##[1:2] s_float)
    else $error("hold entry");
  a_latch_floats: assert property (
    $rose(in_hold) |-> ##[2:12] address_latch_oe_n)
    else $error("latch not released");
  a_float_only_hold: assert property (
    ctrl_oe_n |-> in_hold || $past(in_hold))
    else $error("float outside hold");
  a_no_cycle_hold: assert property (
    in_hold |-> !cyc_accept) else $error("cycle in hold");
  a_fetch_page: assert property (
    address_latch && code[3:1] == 3'h1 && $stable(page_status_bit)
    |-> page_select_n != page_status_bit) else $error("fetch page");
  a_internal_page: assert property (
    address_latch && storage_cycle_n |-> page_select_n)
    else $error("page not high");
  a_reset_code_kept: assert property (
    reset_code_req && $past(reset_code_req) && $past(reset_code_req, 2) &&
    !in_hold |-> code == 4'hA)
    else $error("reset code");
  a_ready_stalls: assert property (
    !ready [*8] |=> !cyc_done) else $error("done while stalled");
  a_hold_waits_ready: assert property (
    (in_hold && !ready) [*8] |=> in_hold) else $error("hold left early");
endmodule // lbph_checker

bind lbph_bus_ctrl lbph_checker u_chk (.*);

// ===== sim/lbph_far_side.sv
// dma requester, ready logic and segment decode beside the bus
`timescale 1ns/100ps
module lbph_far_side (
  input wire clk,
  input wire resetn,
  input wire dma_go,
  input wire [3:0] wait_states,
  input wire address_latch,
  input wire storage_cycle_n,
  input wire [2:0] bus_status_code,
  input wire page_select_n,
  input wire [3:0] addr_hi,
  output wire hold_n,
  output wire ready,
  output wire instr_seg,
  output wire [3:0] map_hi
);
  reg [5:0] stall;
  reg last_latch;
  reg last_hold_n;
  // request held until transfers end; no bus drive of its own
  assign hold_n = !dma_go;
  // third status line ignored in the decode
  assign instr_seg = !storage_cycle_n && bus_status_code[2:1] == 2'b01;
  // mapper stand-in: translates only while page select low
  assign map_hi = page_select_n ? addr_hi : ~addr_hi;
  // low at once on hold release so the first sample already waits
  assign ready = stall == 6'h00 && !(hold_n && !last_hold_n);
  // slow device: wait_states machine states per cycle or release
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall <= 6'h00;
      last_latch <= 1'b0;
      last_hold_n <= 1'b1;
    end else begin
      last_latch <= address_latch;
      last_hold_n <= hold_n;
      if ((address_latch && !last_latch) || (hold_n && !last_hold_n))
        stall <= {wait_states, 2'b00};
      else if (stall != 6'h00)
        stall <= stall - 6'h01;
    end
  end
endmodule // lbph_far_side

// ===== sim/tb_top.sv
// self-checking bench for the local bus control block
`timescale 1ns/100ps
module tb_top;
  logic clk, resetn, reset_code_req, cyc_req, cyc_write, dma_go;
  logic page_status_bit, force_page_high, load_status_strobe;
  logic load_status_value, long_source_prefix, long_dest_prefix;
  logic operand_is_source, operand_is_dest;
  logic [1:0] cyc_kind;
  logic [3:0] cyc_code, wait_states;
  logic [15:0] cyc_addr;
  wire hold_n, ready, instr_seg, cyc_done, cyc_accept, clock_output;
  wire address_latch, address_latch_oe_n, storage_cycle_n, read_write_n;
  wire read_strobe_n, write_strobe_io_clock, ctrl_oe_n, ad_oe_n;
  wire page_select_n, in_hold;
  wire [3:0] map_hi;
  wire [2:0] bus_status_code;
  wire [15:0] ad_out;
  integer mismatches = 0, check_count = 0, cycles = 0, accepts = 0, n;
  lbph_bus_ctrl u_dut (.*, .cyc_wdata(~cyc_addr));
  lbph_far_side u_far (.*, .addr_hi(ad_out[15:12]));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the whole sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      final_report;
    end
  end
  always @(negedge clk) if (cyc_accept === 1'b1) accepts++;
  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function logic sig(input int s);
    case (s)
      0: sig = cyc_accept;
      1: sig = address_latch & ~address_latch_oe_n;
      2: sig = cyc_done;
      3: sig = in_hold;
      4: sig = ~in_hold;
      default: sig = address_latch_oe_n;
    endcase
  endfunction
  // bounded wait; n keeps the elapsed cycles for latency checks
  task await(input int s, input int lim);
    n = 0;
    // first look half a clock on, never in the launching time step
    @(negedge clk);
    while (sig(s) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(n < lim, "no answer");
  endtask
  // one whole bus cycle, judged at its latch pulse and at done
  task cyc(input [1:0] k, input [3:0] c, input [1:0] op, input exp);
    @(posedge clk);
    {cyc_kind, cyc_code, cyc_write} <= {k, c, c[0]};
    {operand_is_source, operand_is_dest} <= op;
    cyc_addr <= {c, 12'h5A3};
    cyc_req <= 1;
    await(0, 40);
    @(posedge clk) cyc_req <= 0;
    await(1, 20);
    chk({storage_cycle_n, bus_status_code} === c, "code");
    chk(page_select_n === exp, "page");
    chk(instr_seg === (c[3:1] == 3'h1), "segment");
    chk({page_select_n, ad_out} === {exp, c, 12'h5A3}, "addr");
    chk(map_hi === (exp ? c : ~c), "mapper");
    chk(read_write_n === (k != 2'h2 && !c[0]), "dir");
    await(2, 80);
    chk(n >= 4 * wait_states + 2 && n <= 4 * wait_states + 11, "len");
    chk({read_strobe_n, write_strobe_io_clock} === {c[0], !c[0]},
        "strobe");
  endtask
  task t_reset_hold;
    repeat (4) begin
      @(negedge clk);
      chk({in_hold, storage_cycle_n, bus_status_code} === 5'h0A, "rst");
    end
    @(posedge clk) {reset_code_req, cyc_req} <= 2'b01;
    await(3, 40);
    repeat (12) @(negedge clk);
    chk(accepts === 0 && address_latch_oe_n, "hold at reset");
    @(posedge clk) dma_go <= 0;
    await(0, 60);
    @(posedge clk) cyc_req <= 0;
    await(2, 80);
    $display("test reset_hold done");
  endtask
  task t_pages;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) page_status_bit <= i[0];
      cyc(0, i[1] ? 4'h2 : 4'h3, 0, !i[0]);
    end
    @(posedge clk) {load_status_strobe, page_status_bit} <= 2'b10;
    @(posedge clk) {load_status_strobe, page_status_bit} <= 2'b01;
    load_status_value <= 1;
    @(posedge clk) load_status_strobe <= 0;
    cyc(0, 4'h3, 0, 0);
    cyc(1, 4'hB, 0, 1);
    @(posedge clk) force_page_high <= 1;
    cyc(0, 4'h5, 0, 1);
    @(posedge clk) {force_page_high, long_source_prefix} <= 2'b01;
    @(posedge clk) long_source_prefix <= 0;
    cyc(0, 4'h3, 0, 0);
    cyc(0, 4'h1, 2'b10, 1);
    cyc(0, 4'h4, 2'b01, 0);
    @(posedge clk) long_dest_prefix <= 1;
    @(posedge clk) long_dest_prefix <= 0;
    cyc(0, 4'h3, 0, 0);
    cyc(0, 4'h4, 2'b01, 1);
    cyc(0, 4'h1, 2'b10, 0);
    $display("test pages done");
  endtask
  task t_waits;
    for (int w = 0; w < 4; w++) begin
      @(posedge clk) wait_states <= w[3:0];
      cyc(w[0] ? 2 : 0, w[0] ? 4'h9 : 4'h7, 0, w[0]);
    end
    @(posedge clk) wait_states <= 0;
    $display("test waits done");
  endtask
  // hold raised inside a write cycle under the interlocked source code
  task t_hold;
    logic p;
    int k;
    @(posedge clk) {cyc_kind, cyc_code, cyc_req} <= 7'h01;
    await(0, 40);
    @(posedge clk) {cyc_req, dma_go} <= 2'b01;
    await(3, 40);
    chk({storage_cycle_n, read_write_n, bus_status_code} === 5'h1F, "ack");
    await(5, 12);
    chk(ctrl_oe_n && ad_oe_n, "float");
    k = 0;
    p = clock_output;
    repeat (16) begin
      @(negedge clk);
      k += clock_output != p;
      p = clock_output;
      chk(address_latch_oe_n && ctrl_oe_n, "held float");
    end
    chk(k == 8, "clock in hold");
    @(posedge clk) {wait_states, dma_go} <= 5'h04;
    repeat (10) @(negedge clk);
    chk(in_hold, "wait on ready");
    await(4, 40);
    @(negedge clk);
    chk(!ctrl_oe_n && !address_latch_oe_n, "bus back");
    @(posedge clk) wait_states <= 0;
    cyc(0, 4'h7, 0, 0);
    $display("test hold done");
  endtask
  // reset in mid-run without hold: reset code, then cycles run again
  task t_mid_reset;
    @(posedge clk) reset_code_req <= 1;
    repeat (3) @(negedge clk);
    repeat (4) begin
      @(negedge clk);
      chk({in_hold, storage_cycle_n, bus_status_code} === 5'h0A, "mid rst");
    end
    @(posedge clk) reset_code_req <= 0;
    cyc(0, 4'h3, 0, 0);
    $display("test mid_reset done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {resetn, cyc_req, cyc_write, page_status_bit, force_page_high} = 0;
    {load_status_strobe, load_status_value, long_source_prefix} = 0;
    {long_dest_prefix, operand_is_source, operand_is_dest} = 0;
    {cyc_kind, wait_states, cyc_addr} = 0;
    {reset_code_req, dma_go, cyc_code} = 6'h33;
    repeat (10) @(posedge clk);
    resetn <= 1;
    t_reset_hold;
    t_pages;
    t_waits;
    t_hold;
    t_mid_reset;
    final_report;
  end
endmodule // tb_top
